// file: rtl/sptss_defs.vh
// Constants for the point table select and status display block
`ifndef SPTSS_DEFS_VH
`define SPTSS_DEFS_VH

// ==========================================================
// Timing
`define SPTSS_CLK_HZ        10000000
`define SPTSS_READY_SHOW_S  2
`define SPTSS_READY_CYCLES  (`SPTSS_READY_SHOW_S * `SPTSS_CLK_HZ)
`define SPTSS_CNT_W         25
// Last count of one millisecond of dwell at 10 MHz
`define SPTSS_MS_LAST       14'h270f

// ==========================================================
// Table geometry and position ranges
`define SPTSS_ENTRIES       255
`define SPTSS_POS_MAX       32'sd9999999
`define SPTSS_POS_MIN       -32'sd9999999
`define SPTSS_RATED_RPM     16'd3000

// ==========================================================
// Glyph codes (5 bit): 0..9 digits, letters above
`define SPTSS_G_BLANK       5'h1f
`define SPTSS_G_A           5'h0a
`define SPTSS_G_B           5'h0b
`define SPTSS_G_C           5'h0c
`define SPTSS_G_D           5'h0d
`define SPTSS_G_8           5'h08

// ==========================================================
// Display states
`define SPTSS_S_WAIT        3'h0
`define SPTSS_S_NREADY      3'h1
`define SPTSS_S_READY       3'h2
`define SPTSS_S_RUN         3'h3
`define SPTSS_S_ALARM       3'h4
`define SPTSS_S_CPUERR      3'h5

// ==========================================================
// Motion states
`define SPTSS_M_IDLE        2'h0
`define SPTSS_M_MOVE        2'h1
`define SPTSS_M_DWELL       2'h2

`endif

// file: rtl/sptss_top.v
// Point table selection, automatic move start and status display
// Notes on behaviour
// - Comms wait shows b plus station
// - Servo-on ready shows d for 2 s
// - Init not done or servo off shows C plus station
// - After ready, show executing entry 0-255
// - Alarm or warning shows A plus number
// - Watchdog error shows 888
// - Suffix 00 in test mode, else station
// - Select entry, then start on fwd/rev
// - Absolute mode: position is target address
// - Incremental mode: position is travel distance
// - Store up to 255 entries
// - Entry holds position, speed, accel, decel, dwell, aux
// - Dwell inserts wait in continuous operation
// - Entry number is 8-bit binary select with two stations, else 5-bit
// - Two stations allow register entry select
// - Status on three-digit seven-segment display
`timescale 1ns/10ps
`include "sptss_defs.vh"

module sptss_top (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Fieldbus status and station
  input  wire        link_up_i,
  input  wire        init_done_i,
  input  wire        servo_on_i,
  input  wire        alarm_i,
  input  wire        warning_i,
  input  wire [7:0]  alarm_num_i,
  input  wire        cpu_wdt_err_i,
  input  wire        test_mode_i,
  input  wire [6:0]  station_i,
  input  wire        two_stations_i,
  // Remote start and select bits
  input  wire        servo_on_fwd_start_bit_i,
  input  wire        reverse_start_bit_i,
  input  wire [4:0]  entry_select_low_i,
  input  wire [2:0]  entry_select_high_i,
  input  wire        reg_select_en_i,
  input  wire [7:0]  reg_entry_num_i,
  // Table write port
  input  wire        tbl_we_i,
  input  wire [7:0]  tbl_addr_i,
  input  wire [31:0] tbl_pos_i,
  input  wire [15:0] tbl_speed_i,
  input  wire [15:0] tbl_accel_i,
  input  wire [15:0] tbl_decel_i,
  input  wire [15:0] tbl_dwell_i,
  input  wire [7:0]  tbl_aux_i,
  input  wire        incremental_mode_i,
  input  wire [3:0]  feed_length_multiplier_i,
  input  wire [31:0] current_addr_i,
  input  wire        move_done_i,
  // Move command toward the profile generator
  output reg         move_start_o,
  output reg         move_reverse_o,
  output reg  [31:0] move_target_o,
  output reg  [31:0] move_distance_o,
  output reg  [15:0] move_speed_o,
  output reg  [15:0] move_accel_o,
  output reg  [15:0] move_decel_o,
  output reg  [7:0]  move_aux_o,
  output reg  [3:0]  move_feed_mult_o,
  output reg         busy_o,
  output reg  [7:0]  exec_entry_o,
  // Display
  output reg  [6:0]  seg_hund_o,
  output reg  [6:0]  seg_tens_o,
  output reg  [6:0]  seg_ones_o
);

  // ========================================================
  // Helpers
  // Glyph to segments gfedcba, used for all three digits
  function [6:0] glyph_seg;
    input [4:0] g;
    begin
      case (g)
        5'h00: glyph_seg = 7'h3f;
        5'h01: glyph_seg = 7'h06;
        5'h02: glyph_seg = 7'h5b;
        5'h03: glyph_seg = 7'h4f;
        5'h04: glyph_seg = 7'h66;
        5'h05: glyph_seg = 7'h6d;
        5'h06: glyph_seg = 7'h7d;
        5'h07: glyph_seg = 7'h07;
        5'h08: glyph_seg = 7'h7f;
        5'h09: glyph_seg = 7'h6f;
        5'h0a: glyph_seg = 7'h77;
        5'h0b: glyph_seg = 7'h7c;
        5'h0c: glyph_seg = 7'h39;
        5'h0d: glyph_seg = 7'h5e;
        default: glyph_seg = 7'h00;
      endcase
    end
  endfunction

  // Binary to three decimal glyphs (value below 256)
  function [14:0] dec3;
    input [7:0] v;
    reg   [7:0] h;
    reg   [7:0] r;
    reg   [7:0] q;
    reg   [7:0] m;
    begin
      h    = v / 8'd100;
      r    = v - h * 8'd100;
      q    = r / 8'd10;
      m    = r % 8'd10;
      dec3 = {h[4:0], q[4:0], m[4:0]};
    end
  endfunction

  // ========================================================
  // Point table storage
  reg [31:0] tbl_pos   [1:`SPTSS_ENTRIES];
  reg [15:0] tbl_speed [1:`SPTSS_ENTRIES];
  reg [15:0] tbl_accel [1:`SPTSS_ENTRIES];
  reg [15:0] tbl_decel [1:`SPTSS_ENTRIES];
  reg [15:0] tbl_dwell [1:`SPTSS_ENTRIES];
  reg [7:0]  tbl_aux   [1:`SPTSS_ENTRIES];

  // Entry 0 is never stored; writes to it are dropped
  always @(posedge clk_i) begin
    if (tbl_we_i && tbl_addr_i != 8'h00) begin
      tbl_pos[tbl_addr_i]   <= tbl_pos_i;
      tbl_speed[tbl_addr_i] <= tbl_speed_i;
      tbl_accel[tbl_addr_i] <= tbl_accel_i;
      tbl_decel[tbl_addr_i] <= tbl_decel_i;
      tbl_dwell[tbl_addr_i] <= tbl_dwell_i;
      tbl_aux[tbl_addr_i]   <= tbl_aux_i;
    end
  end

  // ========================================================
  // Entry selection and start detection
  wire [7:0] bit_sel;
  wire [7:0] sel_num;
  reg        fwd_q;
  reg        rev_q;
  wire       fwd_rise;
  wire       rev_rise;

  // Upper bits only exist when two stations are occupied
  assign bit_sel  = {two_stations_i ? entry_select_high_i : 3'h0,
                     entry_select_low_i};
  assign sel_num  = (two_stations_i && reg_select_en_i) ?
                    reg_entry_num_i : bit_sel;
  assign fwd_rise = servo_on_fwd_start_bit_i & ~fwd_q;
  assign rev_rise = reverse_start_bit_i & ~rev_q;

  // ========================================================
  // Motion sequencer
  reg [1:0]  mstate;
  reg [15:0] dwell_cnt;
  reg [13:0] ms_cnt;
  wire       go;
  wire       ready;
  wire signed [31:0] pos_s;

  // Start ignored with entry 0, while busy or not ready
  assign go    = (fwd_rise | rev_rise) && sel_num != 8'h00 &&
                 mstate == `SPTSS_M_IDLE && ready;
  assign pos_s = tbl_pos[sel_num];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      fwd_q           <= 1'b0;
      rev_q           <= 1'b0;
      mstate          <= `SPTSS_M_IDLE;
      dwell_cnt       <= 16'h0000;
      ms_cnt          <= 14'h0000;
      move_start_o    <= 1'b0;
      move_reverse_o  <= 1'b0;
      move_target_o   <= 32'h00000000;
      move_distance_o <= 32'h00000000;
      move_speed_o    <= 16'h0000;
      move_accel_o    <= 16'h0000;
      move_decel_o    <= 16'h0000;
      move_aux_o      <= 8'h00;
      move_feed_mult_o <= 4'h0;
      busy_o          <= 1'b0;
      exec_entry_o    <= 8'h00;
    end else begin
      fwd_q        <= servo_on_fwd_start_bit_i;
      rev_q        <= reverse_start_bit_i;
      move_start_o <= 1'b0;
      case (mstate)
        `SPTSS_M_IDLE: begin
          if (go) begin
            exec_entry_o   <= sel_num;
            move_start_o   <= 1'b1;
            move_reverse_o <= rev_rise & ~fwd_rise;
            move_feed_mult_o <= feed_length_multiplier_i;
            move_speed_o   <= tbl_speed[sel_num];
            move_accel_o   <= tbl_accel[sel_num];
            move_decel_o   <= tbl_decel[sel_num];
            move_aux_o     <= tbl_aux[sel_num];
            dwell_cnt      <= tbl_dwell[sel_num];
            busy_o         <= 1'b1;
            if (incremental_mode_i) begin
              // Out-of-range values saturate at the range limit
              move_distance_o <= (pos_s < 0) ? 32'h00000000 :
                (pos_s > `SPTSS_POS_MAX) ? `SPTSS_POS_MAX : pos_s;
              move_target_o <= rev_rise & ~fwd_rise ?
                current_addr_i - pos_s : current_addr_i + pos_s;
            end else begin
              move_target_o <= (pos_s > `SPTSS_POS_MAX) ? `SPTSS_POS_MAX :
                (pos_s < `SPTSS_POS_MIN) ? `SPTSS_POS_MIN : pos_s;
              move_distance_o <= ($signed(current_addr_i) > pos_s) ?
                current_addr_i - pos_s : pos_s - current_addr_i;
            end
            mstate <= `SPTSS_M_MOVE;
          end
        end
        `SPTSS_M_MOVE: begin
          if (move_done_i) begin
            ms_cnt <= 14'h0000;
            mstate <= `SPTSS_M_DWELL;
          end
        end
        `SPTSS_M_DWELL: begin
          // Dwell counts in milliseconds before the next start
          if (dwell_cnt == 16'h0000) begin
            busy_o <= 1'b0;
            mstate <= `SPTSS_M_IDLE;
          end else if (ms_cnt == `SPTSS_MS_LAST) begin
            ms_cnt    <= 14'h0000;
            dwell_cnt <= dwell_cnt - 16'h0001;
          end else begin
            ms_cnt <= ms_cnt + 14'h0001;
          end
        end
        default: mstate <= `SPTSS_M_IDLE;
      endcase
    end
  end

  // ========================================================
  // Display state machine
  reg [2:0]            dstate;
  reg [`SPTSS_CNT_W-1:0] hold_cnt;
  reg [2:0]            next_dstate;

  assign ready = dstate == `SPTSS_S_RUN || dstate == `SPTSS_S_READY;

  // Priority chain: watchdog, alarm, then ready progression
  always @* begin
    next_dstate = dstate;
    if (cpu_wdt_err_i)
      next_dstate = `SPTSS_S_CPUERR;
    else if (alarm_i | warning_i)
      next_dstate = `SPTSS_S_ALARM;
    else if (!link_up_i)
      next_dstate = `SPTSS_S_WAIT;
    else if (!init_done_i || !servo_on_i)
      next_dstate = `SPTSS_S_NREADY;
    else if (dstate == `SPTSS_S_READY) begin
      if (hold_cnt == `SPTSS_READY_CYCLES - 1)
        next_dstate = `SPTSS_S_RUN;
    end else if (dstate != `SPTSS_S_RUN)
      next_dstate = `SPTSS_S_READY;
  end

  // Hold counter restarts on every entry to the ready indication
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dstate   <= `SPTSS_S_WAIT;
      hold_cnt <= {`SPTSS_CNT_W{1'b0}};
    end else begin
      dstate <= next_dstate;
      if (next_dstate != `SPTSS_S_READY || dstate != `SPTSS_S_READY)
        hold_cnt <= {`SPTSS_CNT_W{1'b0}};
      else
        hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // ========================================================
  // Glyph selection and segment drive
  wire [7:0]  suffix;
  wire [14:0] suf_g;
  wire [14:0] ent_g;
  wire [14:0] alm_g;
  reg  [14:0] glyphs;

  assign suffix = test_mode_i ? 8'h00 : {1'b0, station_i};
  assign suf_g  = dec3(suffix);
  assign ent_g  = dec3(exec_entry_o);
  assign alm_g  = dec3(alarm_num_i);

  always @* begin
    case (dstate)
      `SPTSS_S_WAIT:   glyphs = {`SPTSS_G_B, suf_g[9:0]};
      `SPTSS_S_NREADY: glyphs = {`SPTSS_G_C, suf_g[9:0]};
      `SPTSS_S_READY:  glyphs = {`SPTSS_G_D, suf_g[9:0]};
      `SPTSS_S_RUN:    glyphs = ent_g;
      `SPTSS_S_ALARM:  glyphs = {`SPTSS_G_A, alm_g[9:0]};
      `SPTSS_S_CPUERR: glyphs = {3{`SPTSS_G_8}};
      default:         glyphs = {3{`SPTSS_G_BLANK}};
    endcase
  end

  // Segments registered so the display never glitches
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      seg_hund_o <= 7'h00;
      seg_tens_o <= 7'h00;
      seg_ones_o <= 7'h00;
    end else begin
      seg_hund_o <= glyph_seg(glyphs[14:10]);
      seg_tens_o <= glyph_seg(glyphs[9:5]);
      seg_ones_o <= glyph_seg(glyphs[4:0]);
    end
  end

endmodule // sptss_top

// file: test/sptss_asserts.sv
// Checker for start pulses, busy and the status display
`timescale 1ns/10ps
module sptss_asserts (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire        cpu_wdt_err_i,
  input wire        alarm_i,
  input wire        warning_i,
  input wire        servo_on_fwd_start_bit_i,
  input wire        reverse_start_bit_i,
  input wire        move_start_o,
  input wire        busy_o,
  input wire [7:0]  exec_entry_o,
  input wire [31:0] move_target_o,
  input wire [15:0] move_speed_o,
  input wire [6:0]  seg_hund_o,
  input wire [6:0]  seg_tens_o,
  input wire [6:0]  seg_ones_o
);
  reg  [1:0]  cpu_q;
  reg  [1:0]  alm_q;
  wire        fw = servo_on_fwd_start_bit_i;
  wire        rv = reverse_start_bit_i;
  // ==========================================================
  // Fault history, since the display lags its cause by two edges
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_q <= 2'h0;
      alm_q <= 2'h0;
    end else begin
      cpu_q <= {cpu_q[0], cpu_wdt_err_i};
      alm_q <= {alm_q[0], alarm_i | warning_i};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Start handshake
  a_start_pulse: assert property (move_start_o |=> !move_start_o)
    else $error("start pulse too long");
  a_start_edge: assert property (move_start_o |->
    ($past(fw) && !$past(fw, 2)) || ($past(rv) && !$past(rv, 2)))
    else $error("start without rising start bit");
  a_start_entry: assert property (move_start_o |-> exec_entry_o != 8'h00)
    else $error("start on entry zero");
  a_start_idle: assert property (move_start_o |-> busy_o && !$past(busy_o))
    else $error("start while busy or busy not set");
  // ==========================================================
  // Display priority
  a_cpu_888: assert property (cpu_q == 2'h3 |->
    {seg_hund_o, seg_tens_o, seg_ones_o} == {3{7'h7f}})
    else $error("watchdog error not shown as 888");
  a_alarm_glyph: assert property (alm_q == 2'h3 && cpu_q == 2'h0
    |-> seg_hund_o == 7'h77) else $error("alarm glyph missing");
  // Move fields stand between starts
  a_target_hold: assert property (!move_start_o |-> $stable(move_target_o))
    else $error("target changed without start");
  a_speed_hold: assert property (!move_start_o |-> $stable(move_speed_o))
    else $error("speed changed without start");
endmodule // sptss_asserts

// file: test/sptss_master.sv
// Fieldbus master model: entry select, then start bit
`timescale 1ns/10ps
module sptss_master (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire       rev_i,
  input  wire       via_reg_i,
  input  wire [7:0] entry_i,
  output reg        fwd_o,
  output reg        rev_o,
  output reg        reg_en_o,
  output reg  [7:0] sel_o,
  output reg  [7:0] reg_num_o
);
  reg [1:0] ph = 2'h0;
  initial {fwd_o, rev_o, reg_en_o, sel_o, reg_num_o} = 'h0;
  // ==========================================================
  // Select first, start next cycle; unused path shows garbage
  always @(negedge clk_i) begin
    if (ph == 2'h0 && go_i) begin
      sel_o <= via_reg_i ? ~entry_i : entry_i;
      reg_num_o <= via_reg_i ? entry_i : ~entry_i;
      reg_en_o <= via_reg_i;
      ph <= 2'h1;
    end else if (ph == 2'h1) begin
      fwd_o <= !rev_i;
      rev_o <= rev_i;
      ph <= 2'h2;
    end else if (ph == 2'h2) begin
      ph <= 2'h3;
    end else if (ph == 2'h3) begin
      fwd_o <= 1'b0;
      rev_o <= 1'b0;
      sel_o <= ~sel_o;
      reg_num_o <= ~reg_num_o;
      ph <= 2'h0;
    end
  end
endmodule // sptss_master

// file: test/tb_top.sv
// Testbench for the point table select and status block
`timescale 1ns/10ps
module tb_top;
  reg clk_i = 1'b0, sys_rst_i, link_up_i, init_done_i, servo_on_i, alarm_i;
  reg warning_i, cpu_wdt_err_i, test_mode_i, two_stations_i, tbl_we_i;
  reg incremental_mode_i, move_done_i, go, rv, ur;
  reg [6:0] station_i;
  reg [7:0] alarm_num_i, tbl_addr_i, tbl_aux_i, ent;
  reg [15:0] tbl_speed_i, tbl_accel_i, tbl_decel_i, tbl_dwell_i;
  reg [31:0] tbl_pos_i, current_addr_i, rng;
  reg [3:0] feed_length_multiplier_i;
  wire servo_on_fwd_start_bit_i, reverse_start_bit_i, reg_select_en_i;
  wire [7:0] sel, reg_entry_num_i, move_aux_o, exec_entry_o;
  wire [4:0] entry_select_low_i = sel[4:0];
  wire [2:0] entry_select_high_i = sel[7:5];
  wire move_start_o, move_reverse_o, busy_o;
  wire [31:0] move_target_o, move_distance_o;
  wire [15:0] move_speed_o, move_accel_o, move_decel_o;
  wire [3:0] move_feed_mult_o;
  wire [6:0] seg_hund_o, seg_tens_o, seg_ones_o;
  wire [20:0] disp = {seg_hund_o, seg_tens_o, seg_ones_o};
  integer bad_count = 0, checked = 0, n, k;
  // Glyphs gfedcba: digits 0-9, then A b C d
  localparam [97:0] SEGT = {7'h5e, 7'h39, 7'h7c, 7'h77, 7'h6f, 7'h7f,
    7'h07, 7'h7d, 7'h6d, 7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
  sptss_top sptss_top_i (.*);
  sptss_master sptss_master_i (.clk_i, .go_i(go), .rev_i(rv), .via_reg_i(ur),
    .entry_i(ent), .fwd_o(servo_on_fwd_start_bit_i),
    .rev_o(reverse_start_bit_i), .reg_en_o(reg_select_en_i), .sel_o(sel),
    .reg_num_o(reg_entry_num_i));
  always #50 clk_i = ~clk_i;
  // ==========================================================
  // Expectation helpers
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [20:0] ed(input [7:0] g, input [7:0] v);
    ed = {SEGT[g*7 +: 7], SEGT[(v/10)*7 +: 7], SEGT[(v%10)*7 +: 7]};
  endfunction
  // Odd entries signed, even ones fit incremental range
  function [31:0] pv(input [7:0] e);
    pv = e[0] ? xs(32'h15cf0 + e) % 32'h1312cff - 32'h98967f
              : xs(32'h15cf0 + e) % 32'h989680;
  endfunction
  function [15:0] fv(input [7:0] e, input [1:0] f);
    reg [31:0] t;
    begin
      t = xs(32'h15cf0 ^ {22'h0, f, e});
      fv = t[15:0];
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge clk_i);
  endtask
  // One move; a second start during it must be ignored
  task run(input [7:0] e, input [7:0] x, input r, input u);
    begin
      ent = e;
      rv = r;
      ur = u;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      for (k = 0; k < 8 && move_start_o !== 1'b1; k = k + 1) cyc(1);
      chk(k < 8, x != 8'h00);
      if (x != 8'h00) begin
        chk(exec_entry_o, x);
        chk(incremental_mode_i ? move_distance_o : move_target_o, pv(x));
        chk({move_speed_o, move_accel_o}, {fv(x, 2'h0), fv(x, 2'h1)});
        chk({move_decel_o, 8'h00, move_aux_o}, {fv(x, 2'h2), fv(x, 2'h3) & 16'h00ff});
        chk({move_feed_mult_o, busy_o}, {feed_length_multiplier_i, 1'b1});
        if (incremental_mode_i) chk(move_reverse_o, r);
        cyc(3);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
          cyc(1);
          chk(move_start_o, 1'b0);
        end
        move_done_i <= 1'b1;
        cyc(1);
        move_done_i <= 1'b0;
        for (k = 0; k < 12000 && busy_o !== 1'b0; k = k + 1) cyc(1);
        chk(k / 10000, x == 8'h03);
        chk(k < 10005, 1'b1);
      end
      $display("move to entry %0d done", x);
    end
  endtask
  // ==========================================================
  // Display states, table load, then moves
  initial begin
    {link_up_i, init_done_i, servo_on_i, alarm_i, warning_i, cpu_wdt_err_i,
      test_mode_i, two_stations_i, tbl_we_i, incremental_mode_i, move_done_i,
      go, rv, ur, alarm_num_i, tbl_addr_i, tbl_aux_i, ent, tbl_speed_i,
      tbl_accel_i, tbl_decel_i, tbl_dwell_i, tbl_pos_i, current_addr_i,
      feed_length_multiplier_i} = 'h0;
    sys_rst_i = 1'b1;
    station_i = 7'h05;
    rng = 32'h15cf0;
    cyc(16);
    sys_rst_i = 1'b0;
    cyc(4);
    chk(disp, ed(8'h0b, 8'h05));
    test_mode_i = 1'b1;
    cyc(4);
    chk(disp, ed(8'h0b, 8'h00));
    test_mode_i = 1'b0;
    link_up_i = 1'b1;
    station_i = 7'h40;
    cyc(4);
    chk(disp, ed(8'h0c, 8'h40));
    warning_i = 1'b1;
    alarm_num_i = 8'h25;
    cyc(4);
    chk(disp, ed(8'h0a, 8'h25));
    cpu_wdt_err_i = 1'b1;
    cyc(4);
    chk(disp, ed(8'h08, 8'h58));
    {cpu_wdt_err_i, warning_i, init_done_i, servo_on_i} = 4'h3;
    cyc(4);
    chk(disp, ed(8'h0d, 8'h40));
    $display("display test done");
    for (n = 1; n < 256; n = n + 1) begin
      {tbl_we_i, tbl_addr_i, tbl_pos_i} = {1'b1, n[7:0], pv(n[7:0])};
      tbl_speed_i = fv(n[7:0], 2'h0);
      tbl_accel_i = fv(n[7:0], 2'h1);
      tbl_decel_i = fv(n[7:0], 2'h2);
      tbl_aux_i = fv(n[7:0], 2'h3) & 16'h00ff;
      tbl_dwell_i = {15'h0, n == 3};
      cyc(1);
    end
    tbl_we_i = 1'b0;
    feed_length_multiplier_i = 4'h2;
    run(8'h00, 8'h00, 1'b0, 1'b0);
    run(8'he5, 8'h05, 1'b1, 1'b0);
    two_stations_i = 1'b1;
    run(8'hff, 8'hff, 1'b0, 1'b0);
    run(8'h03, 8'h03, 1'b0, 1'b0);
    run(8'hc8, 8'hc8, 1'b0, 1'b1);
    for (n = 0; n < 8; n = n + 1) begin
      rng = xs(rng);
      feed_length_multiplier_i = {2'h0, rng[9:8]};
      incremental_mode_i = !rng[0];
      run(rng[7:0], rng[7:0], rng[10], rng[11]);
    end
    complete_run;
  end
  // Watchdog: the run needs about 10500 cycles
  initial begin
    #6000000;
    bad_count = bad_count + 1;
    complete_run;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
endmodule // tb_top
bind sptss_top sptss_asserts sptss_asserts_i (.*);
